/* File: shared/dcb_link_defines.svh */
// Purpose: Shared constants for the DC-balanced three-lane link
// Assumes: One link bit per system clock cycle
// Notes: Frame is sent least significant bit first
`ifndef DCB_LINK_DEFINES_SVH
`define DCB_LINK_DEFINES_SVH

// ----------------------------------------
// Framing
// ----------------------------------------
`define LANES 3
`define DATA_BITS 7
`define FRAME_BITS 9
`define LAST_BIT 4'h8
`define IND_LO 7
`define IND_HI 8
`define IND_INV_POL 1'b1
`define CLK_SHORT_HIGH 4'h4
`define CLK_LONG_HIGH 4'h5

// ----------------------------------------
// Receiver timing
// ----------------------------------------
`define LOCK_PERIODS 32800
`define STALL_CYCLES 5'h12
`define STROBE_HALF 4'h4

`endif

/* File: shared/dcb_link_pkg.sv */
// Purpose: Types shared by both ends of the DC-balanced link
// Assumes: Constants come from dcb_link_defines.svh
// Notes: Types only
`include "dcb_link_defines.svh"

package dcb_link_pkg;

    // ----------------------------------------
    // Words and frames
    // ----------------------------------------
    typedef logic [`DATA_BITS-1:0] lane_word_t;
    typedef logic [`FRAME_BITS-1:0] frame_t;
    typedef logic signed [5:0] digital_sum_span_t;
    typedef logic [3:0] bit_index_t;

    // ----------------------------------------
    // Receiver lock progress
    // ----------------------------------------
    typedef enum logic [1:0] {
        powered_down,
        locking,
        running
    } lock_state_t;

endpackage

/* File: shared/dcb_link_if.sv */
// Purpose: Serial link between serializer and deserializer
// Assumes: All wires change on the system clock
// Notes: Lanes and the forwarded clock are single ended here
`timescale 1ns/1ps

interface dcb_link_if;
    logic serial_lane_zero;
    logic serial_lane_one;
    logic serial_lane_two;
    logic forwarded_clock_in;

    // Sending end drives every wire
    modport serializer (
        output serial_lane_zero,
        output serial_lane_one,
        output serial_lane_two,
        output forwarded_clock_in
    );

    // Receiving end only listens
    modport deserializer (
        input serial_lane_zero,
        input serial_lane_one,
        input serial_lane_two,
        input forwarded_clock_in
    );
endinterface

/* File: logic/dcb_serializer.sv */
// Purpose: Companion serializer applying the DC-balancing code
// Assumes: word_in is held stable until word_take pulses
// Notes: One serial bit per clock, nine bits per frame
`timescale 1ns/1ps
`include "dcb_link_defines.svh"

module dcb_serializer (
    input wire logic clock,
    input wire logic rst,
    dcb_link_if.serializer link,
    input wire logic [20:0] word_in,
    output logic word_take
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Ones minus zeros of a 7-bit word
    function automatic dcb_link_pkg::digital_sum_span_t span7(
        input dcb_link_pkg::lane_word_t w);
        dcb_link_pkg::digital_sum_span_t s;
        s = -6'sd7;
        for (int i = 0; i < `DATA_BITS; i++) begin
            if (w[i]) begin
                s = s + 6'sd2;
            end
        end
        return s;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    dcb_link_pkg::bit_index_t idx_reg, idx_next;
    dcb_link_pkg::frame_t frame_reg [`LANES];
    dcb_link_pkg::frame_t frame_next [`LANES];
    dcb_link_pkg::digital_sum_span_t rds_reg [`LANES];
    dcb_link_pkg::digital_sum_span_t rds_next [`LANES];
    logic long_reg, long_next;
    logic [`LANES-1:0] lane_reg, lane_next;
    logic fclk_reg, fclk_next;

    // Encode a fresh word at each frame boundary
    always_comb begin
        dcb_link_pkg::lane_word_t w;
        dcb_link_pkg::digital_sum_span_t d;
        logic inv;
        w = '0;
        d = '0;
        inv = 1'b0;
        idx_next = (idx_reg == `LAST_BIT) ? 4'h0 : idx_reg + 4'h1;
        long_next = long_reg;
        word_take = 1'b0;
        for (int l = 0; l < `LANES; l++) begin
            frame_next[l] = frame_reg[l];
            rds_next[l] = rds_reg[l];
        end
        if (idx_reg == `LAST_BIT) begin
            word_take = 1'b1;
            long_next = ~long_reg;
            for (int l = 0; l < `LANES; l++) begin
                w = word_in[l*`DATA_BITS +: `DATA_BITS];
                d = span7(w);
                // Invert when word would push the sum further out
                inv = (rds_reg[l] >= 0) ? (d > 0) : (d < 0);
                frame_next[l][`DATA_BITS-1:0] = inv ? ~w : w;
                frame_next[l][`IND_LO] = inv ? `IND_INV_POL : ~`IND_INV_POL;
                frame_next[l][`IND_HI] = ~frame_next[l][`IND_LO];
                rds_next[l] = inv ? rds_reg[l] - d : rds_reg[l] + d;
            end
        end
        for (int l = 0; l < `LANES; l++) begin
            lane_next[l] = frame_next[l][idx_next];
        end
        // Alternating high time keeps the clock lane balanced
        fclk_next = idx_next < (long_next ? `CLK_LONG_HIGH : `CLK_SHORT_HIGH);
    end

    // Register state and pin values
    always_ff @(posedge clock) begin
        if (rst) begin
            idx_reg <= `LAST_BIT;
            long_reg <= 1'b0;
            lane_reg <= '0;
            fclk_reg <= 1'b0;
            for (int l = 0; l < `LANES; l++) begin
                frame_reg[l] <= '0;
                rds_reg[l] <= '0;
            end
        end else begin
            idx_reg <= idx_next;
            long_reg <= long_next;
            lane_reg <= lane_next;
            fclk_reg <= fclk_next;
            for (int l = 0; l < `LANES; l++) begin
                frame_reg[l] <= frame_next[l];
                rds_reg[l] <= rds_next[l];
            end
        end
    end

    // Pins straight from flip-flops
    assign link.serial_lane_zero = lane_reg[0];
    assign link.serial_lane_one = lane_reg[1];
    assign link.serial_lane_two = lane_reg[2];
    assign link.forwarded_clock_in = fclk_reg;

endmodule

/* File: logic/dcb_deserializer.sv */
// Purpose: Receive end of the DC-balanced three-lane link
// Assumes: One serial bit per clock, frame starts at clock rise
// Notes: Outputs tri-state through active-low enables
//
// Contract
// - Lane n drives outputs 7n to 7n+6
// - Sender appends two complementary indicator bits
// - Re-invert words flagged as inverted
// - Sender inverts from running sum sign
// - Running sum counts ones up, zeros down
// - Data lane imbalance never exceeds ten
// - Clock lane imbalance never exceeds five
// - Clock high time alternates four, five ninths
// - Outputs float while power-down input low
// - Strobe at parallel rate, edge variant selectable
// - Forwarded clock kept within rated range
// - Nine bit times per forwarded clock
// - Lock after counted periods, outputs low meanwhile
// - Power-up drives low until lock
// - Stopped forwarded clock forces outputs low
`timescale 1ns/1ps
`include "dcb_link_defines.svh"

module dcb_deserializer #(
    parameter int LOCK_PERIODS = `LOCK_PERIODS,
    parameter bit STROBE_RISING = 1'b1,
    parameter bit IND_POL = `IND_INV_POL
) (
    input wire logic clock,
    input wire logic rst,
    dcb_link_if.deserializer link,
    input wire logic power_down_n,
    output logic [20:0] parallel_data_out,
    output logic data_oe_n,
    output logic parallel_strobe_out,
    output logic strobe_oe_n,
    output logic locked
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Restore one lane word from its frame
    function automatic dcb_link_pkg::lane_word_t restore(
        input dcb_link_pkg::frame_t f);
        logic inv;
        // Only a clean complementary pair counts as inverted
        inv = (f[`IND_LO] == IND_POL) && (f[`IND_HI] != f[`IND_LO]);
        return inv ? ~f[`DATA_BITS-1:0] : f[`DATA_BITS-1:0];
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // All four link wires share one path so alignment survives
    logic [`LANES:0] link_s1, link_s2;
    logic pdn_s1, pdn_s2;

    always_ff @(posedge clock) begin
        if (rst) begin
            link_s1 <= '0;
            link_s2 <= '0;
            pdn_s1 <= 1'b0;
            pdn_s2 <= 1'b0;
        end else begin
            link_s1 <= {link.forwarded_clock_in, link.serial_lane_two,
                        link.serial_lane_one, link.serial_lane_zero};
            link_s2 <= link_s1;
            pdn_s1 <= power_down_n;
            pdn_s2 <= pdn_s1;
        end
    end

    // ----------------------------------------
    // Frame capture
    // ----------------------------------------
    logic fclk_d_reg, fclk_d_next;
    logic rise;
    dcb_link_pkg::frame_t shift_reg [`LANES];
    dcb_link_pkg::frame_t shift_next [`LANES];
    dcb_link_pkg::bit_index_t idx_reg, idx_next;
    logic [4:0] gap_reg, gap_next;
    logic stall;

    // Rise of the forwarded clock marks bit 0 of a new frame
    always_comb begin
        fclk_d_next = link_s2[`LANES];
        rise = link_s2[`LANES] & ~fclk_d_reg;
        for (int l = 0; l < `LANES; l++) begin
            // Serial bits arrive LSB first, so shift in from the top
            shift_next[l] = {link_s2[l], shift_reg[l][`FRAME_BITS-1:1]};
        end
        if (rise) begin
            idx_next = 4'h0;
        end else if (idx_reg != `LAST_BIT) begin
            idx_next = idx_reg + 4'h1;
        end else begin
            idx_next = idx_reg;
        end
        // Saturating gap count catches a stopped or slow clock
        if (rise) begin
            gap_next = 5'h0;
        end else if (gap_reg != `STALL_CYCLES) begin
            gap_next = gap_reg + 5'h1;
        end else begin
            gap_next = gap_reg;
        end
        stall = (gap_reg == `STALL_CYCLES);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            fclk_d_reg <= 1'b0;
            idx_reg <= `LAST_BIT;
            gap_reg <= `STALL_CYCLES;
            for (int l = 0; l < `LANES; l++) begin
                shift_reg[l] <= '0;
            end
        end else begin
            fclk_d_reg <= fclk_d_next;
            idx_reg <= idx_next;
            gap_reg <= gap_next;
            for (int l = 0; l < `LANES; l++) begin
                shift_reg[l] <= shift_next[l];
            end
        end
    end

    // ----------------------------------------
    // Lock tracking
    // ----------------------------------------
    // Counter stands in for the PLL settle time
    dcb_link_pkg::lock_state_t state_reg, state_next;
    logic [15:0] lock_cnt_reg, lock_cnt_next;

    always_comb begin
        state_next = state_reg;
        lock_cnt_next = lock_cnt_reg;
        if (!pdn_s2) begin
            state_next = dcb_link_pkg::powered_down;
            lock_cnt_next = '0;
        end else begin
            unique case (state_reg)
                dcb_link_pkg::powered_down: begin
                    state_next = dcb_link_pkg::locking;
                    lock_cnt_next = '0;
                end
                dcb_link_pkg::locking: begin
                    if (stall) begin
                        lock_cnt_next = '0;
                    end else if (rise) begin
                        // Count whole forwarded clock periods
                        if (lock_cnt_reg == 16'(LOCK_PERIODS - 1)) begin
                            state_next = dcb_link_pkg::running;
                        end else begin
                            lock_cnt_next = lock_cnt_reg + 16'h0001;
                        end
                    end
                end
                dcb_link_pkg::running: begin
                    if (stall) begin
                        // Lost clock means a fresh lock later
                        state_next = dcb_link_pkg::locking;
                        lock_cnt_next = '0;
                    end
                end
                // Spare code falls back to a safe restart
                default: begin
                    state_next = dcb_link_pkg::powered_down;
                    lock_cnt_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= dcb_link_pkg::powered_down;
            lock_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            lock_cnt_reg <= lock_cnt_next;
        end
    end

    // ----------------------------------------
    // Parallel outputs
    // ----------------------------------------
    logic [20:0] data_reg, data_next;
    logic strobe_reg, strobe_next;
    logic oe_n_reg, oe_n_next;
    logic run_next;

    // Data updates only on a frame boundary while running
    always_comb begin
        run_next = (state_next == dcb_link_pkg::running);
        oe_n_next = (state_next == dcb_link_pkg::powered_down);
        data_next = data_reg;
        if (!run_next) begin
            data_next = '0;
        end else if (rise) begin
            for (int l = 0; l < `LANES; l++) begin
                data_next[l*`DATA_BITS +: `DATA_BITS] = restore(shift_reg[l]);
            end
        end
        // Strobe edge lands mid-frame, away from the data change
        if (!run_next) begin
            strobe_next = 1'b0;
        end else if (STROBE_RISING) begin
            strobe_next = (idx_next >= `STROBE_HALF);
        end else begin
            strobe_next = (idx_next < `STROBE_HALF);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            data_reg <= '0;
            strobe_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            data_reg <= data_next;
            strobe_reg <= strobe_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // Enables shared by data and strobe pins
    assign parallel_data_out = data_reg;
    assign parallel_strobe_out = strobe_reg;
    assign data_oe_n = oe_n_reg;
    assign strobe_oe_n = oe_n_reg;
    assign locked = (state_reg == dcb_link_pkg::running);

endmodule

/* File: tb/dcb_link_assertions.sv */
// Purpose: Properties of the first link and its receiver
// Assumes: Rising-edge strobe variant, short lock count
// Notes: Sender faults are judged by the bench instead
`timescale 1ns/1ps

module dcb_link_assertions #(
    parameter int LOCK_PERIODS = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic serial_lane_zero,
    input wire logic serial_lane_one,
    input wire logic serial_lane_two,
    input wire logic forwarded_clock_in,
    input wire logic power_down_n,
    input wire logic [20:0] parallel_data_out,
    input wire logic data_oe_n,
    input wire logic parallel_strobe_out,
    input wire logic strobe_oe_n,
    input wire logic locked
);
    // Counted periods plus sync and a spare frame
    localparam int LOCK_WAIT = LOCK_PERIODS * 9 + 24;
    logic fclk;
    logic strobe;
    logic start;
    logic [2:0] lanes;
    logic fclk_reg;
    logic seen_reg;
    logic signed [5:0] span_reg [3];

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    assign fclk = forwarded_clock_in;
    assign strobe = parallel_strobe_out;
    assign lanes = {serial_lane_two, serial_lane_one, serial_lane_zero};
    assign start = fclk && !fclk_reg;

    // First rise has no whole frame behind it
    always_ff @(posedge clock) begin
        if (rst) begin
            fclk_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            fclk_reg <= fclk;
            seen_reg <= seen_reg || start;
        end
    end

    // Running sum per lane, counted from the first frame on
    always_ff @(posedge clock) begin
        for (int l = 0; l < 3; l++) begin
            if (rst) begin
                span_reg[l] <= 6'sh00;
            end else if (start || seen_reg) begin
                span_reg[l] <= lanes[l] ? span_reg[l] + 6'sh01
                                        : span_reg[l] - 6'sh01;
            end
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_flag_pair;
        @(posedge clock) disable iff (rst)
        start && seen_reg |-> ($past(lanes) ^ $past(lanes, 2)) == 3'h7;
    endproperty
    a_flag_pair: assert property (p_flag_pair)
        else $error("flag pair");
    property p_clk_alt;
        @(posedge clock) disable iff (rst)
        ($rose(fclk) ##1 fclk[*3] ##1 !fclk) |-> ##5 fclk[*5] ##1 !fclk;
    endproperty
    a_clk_alt: assert property (p_clk_alt)
        else $error("clock duty");
    property p_float;
        @(posedge clock) disable iff (rst)
        !power_down_n[*3] |=> data_oe_n;
    endproperty
    a_float: assert property (p_float)
        else $error("not floated");
    property p_oe_pair;
        @(posedge clock) disable iff (rst)
        strobe_oe_n == data_oe_n;
    endproperty
    a_oe_pair: assert property (p_oe_pair)
        else $error("enables differ");
    property p_quiet;
        @(posedge clock) disable iff (rst)
        power_down_n && !data_oe_n && !locked
            |-> parallel_data_out == 21'h00_0000 && !strobe;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("active before lock");
    property p_lock_time;
        @(posedge clock) disable iff (rst)
        $rose(power_down_n) |-> ##[1:LOCK_WAIT] locked;
    endproperty
    a_lock_time: assert property (p_lock_time)
        else $error("lock late");
    property p_strobe_width;
        @(posedge clock) disable iff (rst)
        $fell(strobe) && locked |-> $past(strobe, 5) && !$past(strobe, 6);
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe width");
    property p_launch;
        @(posedge clock) disable iff (rst)
        $changed(parallel_data_out) && locked
            |-> !strobe ##4 ($rose(strobe) || !locked);
    endproperty
    a_launch: assert property (p_launch)
        else $error("strobe phase");
    property p_lane_span;
        @(posedge clock) disable iff (rst)
        span_reg[0] <= 6'sh0A && span_reg[0] >= -6'sh0A
            && span_reg[1] <= 6'sh0A && span_reg[1] >= -6'sh0A
            && span_reg[2] <= 6'sh0A && span_reg[2] >= -6'sh0A;
    endproperty
    a_lane_span: assert property (p_lane_span)
        else $error("lane imbalance");
endmodule

/* File: tb/dc_balanced_lvds_deserializer_bench.sv */
// Purpose: End-to-end bench of the balanced three-lane link
// Assumes: Short lock count, first receiver rising, second falling
// Notes: Second link is hand-driven to break sender rules
`timescale 1ns/1ps

module dc_balanced_lvds_deserializer_bench;
    localparam int LOCKS = 4;
    localparam int LIMIT = 3000;
    logic clock;
    logic rst;
    logic power_down_n;
    logic high_b;
    logic [20:0] word_in;
    logic [20:0] data_a;
    logic [20:0] data_b;
    logic oe_a;
    logic soe_a;
    logic strobe_a;
    logic locked_a;
    logic locked_b;
    logic strobe_b;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;

    dcb_link_if link_a ();
    dcb_link_if link_b ();

    // ----------------------------------------
    // Ends under test
    // ----------------------------------------
    dcb_serializer dcb_serializer_i (.clock(clock), .rst(rst),
        .link(link_a), .word_in(word_in), .word_take());
    dcb_deserializer #(.LOCK_PERIODS(LOCKS)) dcb_deserializer_i (
        .clock(clock), .rst(rst), .link(link_a),
        .power_down_n(power_down_n), .parallel_data_out(data_a),
        .data_oe_n(oe_a), .parallel_strobe_out(strobe_a),
        .strobe_oe_n(soe_a), .locked(locked_a));
    // Receiver fed by the bench, so sender faults can be made
    // Falling-edge variant, so both strobe phases get exercised
    dcb_deserializer #(.LOCK_PERIODS(LOCKS), .STROBE_RISING(1'b0))
        dcb_deserializer_b_i (
        .clock(clock), .rst(rst), .link(link_b),
        .power_down_n(power_down_n), .parallel_data_out(data_b),
        .data_oe_n(), .parallel_strobe_out(strobe_b), .strobe_oe_n(),
        .locked(locked_b));
    dcb_link_assertions #(.LOCK_PERIODS(LOCKS)) dcb_link_assertions_i (
        .clock(clock), .rst(rst),
        .serial_lane_zero(link_a.serial_lane_zero),
        .serial_lane_one(link_a.serial_lane_one),
        .serial_lane_two(link_a.serial_lane_two),
        .forwarded_clock_in(link_a.forwarded_clock_in),
        .power_down_n(power_down_n), .parallel_data_out(data_a),
        .data_oe_n(oe_a), .parallel_strobe_out(strobe_a),
        .strobe_oe_n(soe_a), .locked(locked_a));

    // ----------------------------------------
    // Clock, hang guard, helpers
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Run needs under a thousand cycles; ceiling leaves margin
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            test_done();
        end
    end

    task test_done;
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task check(input logic [20:0] got, input logic [20:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task check_bit(input logic got, input logic exp);
        check({20'h0_0000, got}, {20'h0_0000, exp});
    endtask

    // One frame on all three lanes, duty alternating
    task send_b(input logic [8:0] frame);
        for (int i = 0; i < 9; i++) begin
            @(posedge clock);
            link_b.serial_lane_zero <= frame[i];
            link_b.serial_lane_one <= frame[i];
            link_b.serial_lane_two <= frame[i];
            link_b.forwarded_clock_in <= i < (high_b ? 5 : 4);
        end
        high_b = !high_b;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_lock;
        @(posedge clock);
        power_down_n <= 1'b1;
        repeat (5) @(negedge clock);
        check_bit(oe_a, 1'b0);
        check_bit(locked_a, 1'b0);
        check(data_a, 21'h00_0000);
        for (int n = 0; n < 100 && locked_a !== 1'b1; n++) @(negedge clock);
        check_bit(locked_a, 1'b1);
    endtask

    // Lane words apart; all ones alternates plain and inverted frames
    task t_words;
        logic [20:0] w [6];
        w = '{21'h1F_FFFF, 21'h00_0000, 21'h00_007F,
              21'h00_3F80, 21'h1F_C000, 21'h0A_C9E3};
        foreach (w[k]) begin
            @(posedge clock);
            word_in <= w[k];
            repeat (30) @(negedge clock);
            check(data_a, w[k]);
            repeat (9) @(negedge clock);
            check(data_a, w[k]);
        end
    endtask

    task t_power_down;
        @(posedge clock);
        power_down_n <= 1'b0;
        repeat (4) @(negedge clock);
        check_bit(oe_a, 1'b1);
        check_bit(soe_a, 1'b1);
        t_lock();
    endtask

    // Flag pairs as {bit 8, bit 7}; equal pairs are sender faults
    task t_flags;
        logic [1:0] f [4];
        f = '{2'h1, 2'h2, 2'h3, 2'h0};
        repeat (LOCKS + 4) send_b({2'h2, 7'h2D});
        foreach (f[k]) begin
            repeat (3) send_b({f[k], 7'h2D});
            @(negedge clock);
            check(data_b, f[k] == 2'h1 ? {3{7'h52}} : {3{7'h2D}});
            // Frame index 5 here: falling variant is low, rising high
            check_bit(strobe_b, 1'b0);
        end
    endtask

    // Clock parked low, lanes still toggling
    task t_stall;
        repeat (25) begin
            @(posedge clock);
            link_b.forwarded_clock_in <= 1'b0;
            link_b.serial_lane_zero <= ~link_b.serial_lane_zero;
            link_b.serial_lane_one <= ~link_b.serial_lane_one;
            link_b.serial_lane_two <= ~link_b.serial_lane_two;
        end
        @(negedge clock);
        check(data_b, 21'h00_0000);
        check_bit(locked_b, 1'b0);
    endtask

    initial begin
        rst = 1'b1;
        power_down_n = 1'b0;
        word_in = 21'h00_0000;
        high_b = 1'b0;
        link_b.serial_lane_zero = 1'b0;
        link_b.serial_lane_one = 1'b0;
        link_b.serial_lane_two = 1'b0;
        link_b.forwarded_clock_in = 1'b0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_lock();
        t_words();
        t_power_down();
        t_flags();
        t_stall();
        test_done();
    end
endmodule
